//--- design/mps_defs.vh
/*
 constants for the packet security configuration block: register offsets,
 field positions, reset values and mode codes.
 assumes a 32-bit axi4-lite slave with byte addresses index*4.
*/
// How it works
// - standalone key slot follows bit 7
// - transmit key slot follows bit 6
// - receive key slot follows bit 5
// - bits 4:2 code the tag length
// - ctr: tx aux skips bytes before cipher
// - cbc-mac: tx aux skips bytes before auth
// - ccm: tx aux is auth-only length
// - ctr: rx aux skips bytes before decrypt
// - cbc-mac: rx aux skips bytes before auth
// - ccm: rx aux is auth-only length
// - aux bit 7 reserved, fields reset zero
// - engine reset bit initialises the engine
`ifndef MPS_DEFS_VH
`define MPS_DEFS_VH
`define MPS_IDX_CTRL      16'h2190
`define MPS_IDX_SEC       16'h2193
`define MPS_IDX_TRANSMIT_AUX_LENGTH      16'h2194
`define MPS_IDX_RECEIVE_AUX_LENGTH      16'h2195
`define MPS_IDX_STAT      16'h2196
`define MPS_SA_KEY_BIT    7
`define MPS_TX_KEY_BIT    6
`define MPS_RX_KEY_BIT    5
`define MPS_TAG_HI        4
`define MPS_TAG_LO        2
`define MPS_MODE_HI       1
`define MPS_MODE_LO       0
`define MPS_ENG_RST_BIT   4
`define MPS_SEC_RST       8'h00
`define MPS_AUX_RST       7'h00
`define MPS_MODE_NONE     2'h0
`define MPS_MODE_CBC      2'h1
`define MPS_MODE_CTR      2'h2
`define MPS_MODE_CCM      2'h3
`define MPS_RESP_OKAY     2'h0
`define MPS_RESP_SLVERR   2'h2
`define MPS_TAG_LEN6      8'h0c
`define MPS_TAG_LEN7      8'h0e
`endif

//--- design/mps_decode.v
/*
 decodes the security settings into per-direction engine controls.
 assumes registered inputs from the register block on the same clock.
*/
`timescale 1ns/10ps
`include "mps_defs.vh"
module mps_decode (
  // settings
  input  wire [1:0] protection_mode,
  input  wire [2:0] auth_tag_length_code,
  input  wire [6:0] aux_length,
  // engine controls
  output reg        use_cipher,
  output reg        use_auth,
  output reg  [6:0] cipher_skip,
  output reg  [6:0] auth_skip,
  output reg  [6:0] auth_only_len,
  output reg  [7:0] tag_bytes,
  output reg        tag_code_bad
);
  always @* begin
    use_cipher    = 1'b0;
    use_auth      = 1'b0;
    cipher_skip   = 7'h00;
    auth_skip     = 7'h00;
    auth_only_len = 7'h00;
    case (protection_mode)
      `MPS_MODE_CBC: begin
        use_auth  = 1'b1;
        auth_skip = aux_length;
      end
      `MPS_MODE_CTR: begin
        use_cipher  = 1'b1;
        cipher_skip = aux_length;
      end
      `MPS_MODE_CCM: begin
        use_cipher    = 1'b1;
        use_auth      = 1'b1;
        auth_only_len = aux_length;
        cipher_skip   = aux_length;
      end
      default: begin
        use_cipher = 1'b0;
      end
    endcase
  end

  always @* begin
    tag_code_bad = 1'b0;
    case (auth_tag_length_code)
      3'h0:    begin
        tag_bytes    = 8'h00;
        tag_code_bad = 1'b1;
      end
      3'h6:    tag_bytes = `MPS_TAG_LEN6;
      3'h7:    tag_bytes = `MPS_TAG_LEN7;
      default: tag_bytes = {4'h0, auth_tag_length_code, 1'b0} + 8'h02;
    endcase
  end
endmodule // mps_decode

//--- design/mps_config.v
/*
 packet security configuration registers with an axi4-lite slave.
 assumes one clock, synchronous active-low reset, one access at a time.
*/
`timescale 1ns/10ps
`include "mps_defs.vh"
module mps_config (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // engine activity
  input  wire        tx_busy,
  input  wire        rx_busy,
  // key slot choices, 1 = second key slot
  output wire        sa_key_second,
  output wire        tx_key_second,
  output wire        rx_key_second,
  // transmit controls
  output wire        tx_use_cipher,
  output wire        tx_use_auth,
  output wire [6:0]  tx_cipher_skip,
  output wire [6:0]  tx_auth_skip,
  output wire [6:0]  tx_auth_only_len,
  // receive controls
  output wire        rx_use_cipher,
  output wire        rx_use_auth,
  output wire [6:0]  rx_cipher_skip,
  output wire [6:0]  rx_auth_skip,
  output wire [6:0]  rx_auth_only_len,
  // tag and mode
  output wire [7:0]  tag_bytes,
  output wire [1:0]  protection_mode,
  // engine reset pulse
  output reg         engine_init
);
  reg  [7:0]  sec_ff;
  reg  [6:0]  transmit_aux_length_ff;
  reg  [6:0]  receive_aux_length_ff;
  reg         tag_bad_ff;
  reg         aw_held_ff;
  reg         w_held_ff;
  reg  [31:0] awaddr_ff;
  reg  [31:0] wdata_ff;
  reg         wstb_ff;
  wire        tag_bad_now;
  wire        do_write;
  wire [31:0] wr_addr;
  wire [31:0] wr_data;
  wire        wr_lane0;

  function [15:0] word_index;
    input [31:0] addr;
    begin
      word_index = addr[17:2];
    end
  endfunction

  function known_index;
    input [15:0] idx;
    begin
      known_index = (idx == `MPS_IDX_CTRL) || (idx == `MPS_IDX_SEC) ||
                    (idx == `MPS_IDX_TRANSMIT_AUX_LENGTH) || (idx == `MPS_IDX_RECEIVE_AUX_LENGTH) ||
                    (idx == `MPS_IDX_STAT);
    end
  endfunction

  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign wr_addr  = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data  = w_held_ff ? wdata_ff : s_axi_wdata;
  assign wr_lane0 = w_held_ff ? wstb_ff : s_axi_wstrb[0];
  assign do_write = (aw_held_ff || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_ff || (s_axi_wvalid && s_axi_wready));

  // write channel and registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      sec_ff       <= `MPS_SEC_RST;
      transmit_aux_length_ff      <= `MPS_AUX_RST;
      receive_aux_length_ff      <= `MPS_AUX_RST;
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      awaddr_ff    <= 32'h0000_0000;
      wdata_ff     <= 32'h0000_0000;
      wstb_ff      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `MPS_RESP_OKAY;
      engine_init  <= 1'b0;
    end else begin
      engine_init <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_index(word_index(wr_addr)) ? `MPS_RESP_OKAY
                                                         : `MPS_RESP_SLVERR;
        if (wr_lane0) begin
          case (word_index(wr_addr))
            `MPS_IDX_CTRL: engine_init <= wr_data[`MPS_ENG_RST_BIT];
            `MPS_IDX_SEC:  sec_ff      <= wr_data[7:0];
            `MPS_IDX_TRANSMIT_AUX_LENGTH: transmit_aux_length_ff     <= wr_data[6:0];
            `MPS_IDX_RECEIVE_AUX_LENGTH: receive_aux_length_ff     <= wr_data[6:0];
            default:       sec_ff      <= sec_ff;
          endcase
        end
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_ff <= 1'b1;
          awaddr_ff  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_ff <= 1'b1;
          wdata_ff  <= s_axi_wdata;
          wstb_ff   <= s_axi_wstrb[0];
        end
      end
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `MPS_RESP_OKAY;
      tag_bad_ff   <= 1'b0;
    end else begin
      tag_bad_ff <= tag_bad_now;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= known_index(word_index(s_axi_araddr)) ? `MPS_RESP_OKAY
                                                              : `MPS_RESP_SLVERR;
        case (word_index(s_axi_araddr))
          `MPS_IDX_SEC:  s_axi_rdata <= {24'h000000, sec_ff};
          `MPS_IDX_TRANSMIT_AUX_LENGTH: s_axi_rdata <= {25'h0000000, transmit_aux_length_ff};
          `MPS_IDX_RECEIVE_AUX_LENGTH: s_axi_rdata <= {25'h0000000, receive_aux_length_ff};
          `MPS_IDX_STAT: s_axi_rdata <= {29'h00000000, tag_bad_ff, rx_busy, tx_busy};
          default:       s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign sa_key_second   = sec_ff[`MPS_SA_KEY_BIT];
  assign tx_key_second   = sec_ff[`MPS_TX_KEY_BIT];
  assign rx_key_second   = sec_ff[`MPS_RX_KEY_BIT];
  assign protection_mode = sec_ff[`MPS_MODE_HI:`MPS_MODE_LO];

  mps_decode u_tx_dec (
    .protection_mode      (sec_ff[`MPS_MODE_HI:`MPS_MODE_LO]),
    .auth_tag_length_code (sec_ff[`MPS_TAG_HI:`MPS_TAG_LO]),
    .aux_length           (transmit_aux_length_ff),
    .use_cipher           (tx_use_cipher),
    .use_auth             (tx_use_auth),
    .cipher_skip          (tx_cipher_skip),
    .auth_skip            (tx_auth_skip),
    .auth_only_len        (tx_auth_only_len),
    .tag_bytes            (tag_bytes),
    .tag_code_bad         (tag_bad_now)
  );

  mps_decode u_rx_dec (
    .protection_mode      (sec_ff[`MPS_MODE_HI:`MPS_MODE_LO]),
    .auth_tag_length_code (sec_ff[`MPS_TAG_HI:`MPS_TAG_LO]),
    .aux_length           (receive_aux_length_ff),
    .use_cipher           (rx_use_cipher),
    .use_auth             (rx_use_auth),
    .cipher_skip          (rx_cipher_skip),
    .auth_skip            (rx_auth_skip),
    .auth_only_len        (rx_auth_only_len),
    .tag_bytes            (),
    .tag_code_bad         ()
  );
endmodule // mps_config

//--- verification/mps_config_checker.sv
/*
 checker for the security configuration block, bound to its ports.
 assumes write address and data are offered together by the master.
*/
`timescale 1ns/10ps
`include "mps_defs.vh"
module mps_config_checker (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // write bus
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  // controls
  input wire        sa_key_second,
  input wire        tx_key_second,
  input wire        rx_key_second,
  input wire        tx_use_cipher,
  input wire        tx_use_auth,
  input wire [6:0]  tx_cipher_skip,
  input wire [6:0]  tx_auth_only_len,
  input wire        rx_use_cipher,
  input wire        rx_use_auth,
  input wire [7:0]  tag_bytes,
  input wire [1:0]  protection_mode,
  input wire        engine_init
);
  wire        ws  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        wsb = ws && s_axi_wstrb[0];
  wire [15:0] wi  = s_axi_awaddr[17:2];
  wire        sec = wsb && wi == `MPS_IDX_SEC;
  wire        txa = wsb && wi == `MPS_IDX_TRANSMIT_AUX_LENGTH;
  wire [2:0]  tc  = s_axi_wdata[4:2];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_sa_key: assert property (sec |=> sa_key_second == $past(s_axi_wdata[7]))
    else $error("standalone key choice wrong");
  chk_tx_key: assert property (sec |=> tx_key_second == $past(s_axi_wdata[6]))
    else $error("transmit key choice wrong");
  chk_rx_key: assert property (sec |=> rx_key_second == $past(s_axi_wdata[5]))
    else $error("receive key choice wrong");
  chk_tag_len: assert property (sec && tc != 3'h0 && tc < 3'h6 |=>
    tag_bytes == {$past(tc), 1'b0} + 8'h02) else $error("tag length wrong");
  chk_mode_sel: assert property (sec |=> protection_mode == $past(s_axi_wdata[1:0]))
    else $error("mode wrong");
  chk_ctr_use: assert property (protection_mode == `MPS_MODE_CTR |->
    tx_use_cipher && !tx_use_auth && rx_use_cipher && !rx_use_auth) else $error("ctr use");
  chk_cbc_use: assert property (protection_mode == `MPS_MODE_CBC |->
    tx_use_auth && !tx_use_cipher && rx_use_auth && !rx_use_cipher) else $error("cbc use");
  chk_ccm_len: assert property (protection_mode == `MPS_MODE_CCM |-> tx_use_auth &&
    tx_use_cipher && tx_auth_only_len == tx_cipher_skip) else $error("ccm length");
  chk_aux_ctr: assert property (txa |=> protection_mode != `MPS_MODE_CTR ||
    tx_cipher_skip == $past(s_axi_wdata[6:0])) else $error("ctr skip");
  chk_eng_init: assert property (wsb && wi == `MPS_IDX_CTRL && s_axi_wdata[4] |=>
    engine_init ##1 !engine_init) else $error("engine init pulse");
  chk_bvalid_lat: assert property (ws |=> s_axi_bvalid) else $error("write answer late");
  cov_ccm: cover property (protection_mode == `MPS_MODE_CCM);
  cov_init: cover property (engine_init);
  cov_aux: cover property (txa);
endmodule // mps_config_checker
bind mps_config mps_config_checker chk (.*);

//--- verification/mps_config_test.sv
/*
 self-checking bench for the security configuration block.
 assumes readies answer combinationally; answers are compared off a queue.
*/
`timescale 1ns/10ps
`include "mps_defs.vh"
`define CHK(a, e) begin logic [33:0] x_, y_; x_ = a; y_ = e; total_checks++; \
  if (x_ !== y_) begin n_errors++; $display("MISMATCH %0t %h %h", $time, x_, y_); end end
module mps_config_test;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic        s_axi_arvalid = 0, s_axi_rready = 1, tx_busy = 0, rx_busy = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, r = 32'h00012e8c;
  logic [3:0]  s_axi_wstrb = 0;
  logic [7:0]  d;
  logic [33:0] exp_q[$];
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, protection_mode;
  wire  [31:0] s_axi_rdata;
  wire         sa_key_second, tx_key_second, rx_key_second, engine_init;
  wire         tx_use_cipher, tx_use_auth, rx_use_cipher, rx_use_auth;
  wire  [6:0]  tx_cipher_skip, tx_auth_skip, tx_auth_only_len;
  wire  [6:0]  rx_cipher_skip, rx_auth_skip, rx_auth_only_len;
  wire  [7:0]  tag_bytes;
  int          n_errors = 0, total_checks = 0, n_init = 0;
  mps_config uut (.*);
  initial forever #2 aclk = ~aclk;
  function automatic [31:0] lfsr(input [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic [7:0] tlen(input [2:0] c);
    return c == 3'h0 ? 8'h00 : c == 3'h6 ? `MPS_TAG_LEN6 : c == 3'h7 ? `MPS_TAG_LEN7 :
      {4'h0, c, 1'b0} + 8'h02;
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input [15:0] i, input [31:0] v, input [3:0] s, input [1:0] e);
    logic a, w, b;
    exp_q.push_back({e, 32'h0});
    a = 0;
    w = 0;
    s_axi_awaddr <= {14'h0, i, 2'h0};
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(negedge aclk) a |= s_axi_awready;
      w |= s_axi_wready;
      @(posedge aclk) if (a) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end while (!(a && w));
    do begin @(negedge aclk) b = s_axi_bvalid; @(posedge aclk); end while (!b);
  endtask
  task automatic rd(input [15:0] i, input [31:0] v, input [1:0] e);
    logic a, b;
    exp_q.push_back({e, v});
    s_axi_araddr <= {14'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    do begin @(negedge aclk) a = s_axi_arready; @(posedge aclk); end while (!a);
    s_axi_arvalid <= 0;
    do begin @(negedge aclk) b = s_axi_rvalid; @(posedge aclk); end while (!b);
  endtask
  always @(posedge aclk) begin
    if (engine_init) n_init++;
    if (s_axi_bvalid && s_axi_bready) `CHK({s_axi_bresp, 32'h0}, exp_q.pop_front())
    if (s_axi_rvalid && s_axi_rready) `CHK({s_axi_rresp, s_axi_rdata}, exp_q.pop_front())
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int k = 0; k < 3; k++) rd(`MPS_IDX_SEC + k, 32'h0, `MPS_RESP_OKAY);
    for (int k = 0; k < 32; k++) begin
      r = lfsr(r);
      d = {r[7:5], k[2:0], k[4:3]};
      tx_busy <= r[9];
      rx_busy <= r[10];
      wr(`MPS_IDX_SEC, {r[31:8], d}, 4'hf, `MPS_RESP_OKAY);
      rd(`MPS_IDX_SEC, {24'h0, d}, `MPS_RESP_OKAY);
      `CHK({sa_key_second, tx_key_second, rx_key_second}, d[7:5])
      `CHK(tag_bytes, tlen(d[4:2]))
      wr(`MPS_IDX_TRANSMIT_AUX_LENGTH, r, 4'h1, `MPS_RESP_OKAY);
      wr(`MPS_IDX_RECEIVE_AUX_LENGTH, r >> 8, 4'h1, `MPS_RESP_OKAY);
      rd(`MPS_IDX_RECEIVE_AUX_LENGTH, {25'h0, r[14:8]}, `MPS_RESP_OKAY);
      rd(`MPS_IDX_STAT, {29'h0, d[4:2] == 3'h0, r[10:9]}, `MPS_RESP_OKAY);
      case (d[1:0])
        `MPS_MODE_CTR: `CHK({tx_cipher_skip, rx_cipher_skip}, {r[6:0], r[14:8]})
        `MPS_MODE_CBC: `CHK({tx_auth_skip, rx_auth_skip}, {r[6:0], r[14:8]})
        `MPS_MODE_CCM: `CHK({tx_auth_only_len, rx_auth_only_len}, {r[6:0], r[14:8]})
        default: `CHK(tx_cipher_skip | tx_auth_skip | tx_auth_only_len, 7'h0)
      endcase
      `CHK(protection_mode, d[1:0])
      `CHK({tx_use_cipher, tx_use_auth, rx_use_cipher, rx_use_auth}, {2{d[1], d[0]}})
    end
    wr(`MPS_IDX_TRANSMIT_AUX_LENGTH, 32'hff, 4'h0, `MPS_RESP_OKAY);
    rd(`MPS_IDX_TRANSMIT_AUX_LENGTH, {25'h0, r[6:0]}, `MPS_RESP_OKAY);
    wr(`MPS_IDX_CTRL, 32'hef, 4'hf, `MPS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(n_init, 0)
    wr(`MPS_IDX_CTRL, 32'h10, 4'hf, `MPS_RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(n_init, 1)
    rd(`MPS_IDX_CTRL, 32'h0, `MPS_RESP_OKAY);
    wr(16'h2197, 32'h0, 4'hf, `MPS_RESP_SLVERR);
    rd(16'h2197, 32'h0, `MPS_RESP_SLVERR);
    test_done;
  end
  initial begin
    #20000;
    n_errors++;
    test_done;
  end
endmodule // mps_config_test
